// File: rtl/prxi2c_regs.vh
// Register map, field positions, reset values and timing counts for the proximity I2C block
// Operation
// - LED pulse rate is the 4 MHz reference divided by the divisor register.
// - Divisor resets to sixteen, giving 250 KHz with a 4 us period.
// - Receiver sample taken a programmable delay after each LED edge.
// - Code 0 or 1 gives no delay; N gives (N-1) steps of 125 ns.
// - Sample-delay code resets to five, a 500 ns delay.
// - Result is unsigned, 12 bits at default integration, readable over I2C.
// - Every byte is 8 bits, MSB first, followed by one acknowledge bit.
// - Device answers address 0x37; write begins START, address, 0, acknowledged.
// - After address the master sends a register pointer; device acks and loads it.
// - Write stores each data byte, acks it, then advances the pointer.
// - Write ends on STOP or repeated START, either accepted.
// - Read: pointer written, repeated START, address with 1, device drives byte.
// - Master ack on a read byte advances pointer and next byte is driven.
// - High-speed master code enters high-speed mode, kept over repeated STARTs.
// - Any STOP leaves high-speed mode at once.
// - All registers take defaults at power-up and on software reset.
// - Result split across two read-only registers, upper bits at lower address.
// - Each threshold is a register pair, most significant part at lower address.
// - Divisor occupies bits 4 to 0; upper bits are don't-care.
// - Sample-delay code occupies bits 4 to 0; upper bits are don't-care.
// - Writing 1 to reset bit 0 then STOP restores the startup state.
`ifndef PRXI2C_REGS_VH
`define PRXI2C_REGS_VH
`define PRX_SLAVE_ADDR      7'h37
`define PRX_HS_CODE_MASK    8'hF8
`define PRX_HS_CODE         8'h08
`define PRX_ADDR_PART_IDENTIFICATION    8'h00
`define PRX_ADDR_SOFT_RST   8'h01
`define PRX_ADDR_IRQ_CFG    8'h02
`define PRX_ADDR_LED_DIV    8'h0D
`define PRX_ADDR_SMP_DLY    8'h0E
`define PRX_ADDR_LED_CUR    8'h0F
`define PRX_ADDR_UTH_HI     8'h10
`define PRX_ADDR_UTH_LO     8'h11
`define PRX_ADDR_LTH_HI     8'h12
`define PRX_ADDR_LTH_LO     8'h13
`define PRX_ADDR_FILT_CFG   8'h14
`define PRX_ADDR_INTEG_CFG  8'h15
`define PRX_ADDR_INTERVAL   8'h16
`define PRX_ADDR_MODE_CTRL  8'h17
`define PRX_ADDR_IRQ_STAT   8'h40
`define PRX_ADDR_RES_HI     8'h41
`define PRX_ADDR_RES_LO     8'h42
`define PRX_SOFT_RST_BIT    0
`define PRX_FIELD_MSB       4
`define PRX_RST_LED_DIV     5'h10
`define PRX_RST_SMP_DLY     5'h05
`define PRX_RST_IRQ_CFG     8'h02
`define PRX_RST_LED_CUR     8'h09
`define PRX_RST_ZERO        8'h00
`define PRX_REF_HZ          4000000
`define PRX_CLK_HZ          20000000
`define PRX_REF_CYC         (`PRX_CLK_HZ / `PRX_REF_HZ)
`define PRX_STEP_NS         125
`define PRX_CLK_NS          50
`define PRX_STEP_CYC        ((`PRX_STEP_NS + `PRX_CLK_NS - 1) / `PRX_CLK_NS)
`endif

// File: rtl/prxi2c_top.v
// I2C slave register bank with LED pulse divider and receiver sample-delay timing
`timescale 1ns/1ps
`include "prxi2c_regs.vh"
module prxi2c_top #(
  parameter REV_ID = 4'h0,
  parameter PART_NUM = 4'hA
) (
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe_out,
  output reg         hs_mode_out,
  output reg         led_pulse_out,
  output reg         rx_sample_out,
  input  wire [11:0] measurement_result_in,
  output wire [7:0]  led_drive_current_out,
  output wire [7:0]  operation_mode_out
);
  // Part number arbitrary, not a real identification
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_PTR  = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_IGN  = 3'h5;

  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_d_reg;
  reg       sda_d_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always @(posedge clk_in)
  begin
    scl_sync_reg <= {scl_sync_reg[0], scl_in};
    sda_sync_reg <= {sda_sync_reg[0], sda_in};
    scl_d_reg    <= scl_sync_reg[1];
    sda_d_reg    <= sda_sync_reg[1];
  end

  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg       ack_phase_reg;
  reg       sda_drv_reg;
  reg       rst_armed_reg;
  reg       soft_rst_reg;
  reg [7:0] irq_cfg_reg;
  reg [4:0] led_div_reg;
  reg [4:0] smp_dly_reg;
  reg [7:0] led_cur_reg;
  reg [7:0] uth_hi_reg;
  reg [7:0] uth_lo_reg;
  reg [7:0] lth_hi_reg;
  reg [7:0] lth_lo_reg;
  reg [7:0] filt_cfg_reg;
  reg [7:0] integ_cfg_reg;
  reg [7:0] interval_reg;
  reg [7:0] mode_ctrl_reg;
  reg [7:0] res_lo_latch_reg;
  reg [7:0] rd_data;

  wire regs_rst = srst_in | soft_rst_reg;
  assign sda_out = 1'b0;
  assign led_drive_current_out = led_cur_reg;
  assign operation_mode_out    = mode_ctrl_reg;

  // Read mux; unmapped and write-only gaps read zero
  always @*
  begin
    rd_data = `PRX_RST_ZERO;
    if (ptr_reg == `PRX_ADDR_PART_IDENTIFICATION)
      rd_data = {PART_NUM, REV_ID};
    else if (ptr_reg == `PRX_ADDR_SOFT_RST)
      rd_data = `PRX_RST_ZERO;
    else if (ptr_reg == `PRX_ADDR_IRQ_CFG)
      rd_data = irq_cfg_reg;
    else if (ptr_reg == `PRX_ADDR_LED_DIV)
      rd_data = {3'h0, led_div_reg};
    else if (ptr_reg == `PRX_ADDR_SMP_DLY)
      rd_data = {3'h0, smp_dly_reg};
    else if (ptr_reg == `PRX_ADDR_LED_CUR)
      rd_data = led_cur_reg;
    else if (ptr_reg == `PRX_ADDR_UTH_HI)
      rd_data = uth_hi_reg;
    else if (ptr_reg == `PRX_ADDR_UTH_LO)
      rd_data = uth_lo_reg;
    else if (ptr_reg == `PRX_ADDR_LTH_HI)
      rd_data = lth_hi_reg;
    else if (ptr_reg == `PRX_ADDR_LTH_LO)
      rd_data = lth_lo_reg;
    else if (ptr_reg == `PRX_ADDR_FILT_CFG)
      rd_data = filt_cfg_reg;
    else if (ptr_reg == `PRX_ADDR_INTEG_CFG)
      rd_data = integ_cfg_reg;
    else if (ptr_reg == `PRX_ADDR_INTERVAL)
      rd_data = interval_reg;
    else if (ptr_reg == `PRX_ADDR_MODE_CTRL)
      rd_data = mode_ctrl_reg;
    else if (ptr_reg == `PRX_ADDR_IRQ_STAT)
      rd_data = `PRX_RST_ZERO;
    else if (ptr_reg == `PRX_ADDR_RES_HI)
      rd_data = {4'h0, measurement_result_in[11:8]};
    else if (ptr_reg == `PRX_ADDR_RES_LO)
      rd_data = res_lo_latch_reg;
  end

  wire wr_strobe = (state_reg == ST_WDAT) & scl_fall & ~ack_phase_reg & (bit_cnt_reg == 4'h8);

  // Register bank; read-only and unmapped writes drop silently
  always @(posedge clk_in)
  begin
    if (regs_rst)
    begin
      irq_cfg_reg   <= `PRX_RST_IRQ_CFG;
      led_div_reg   <= `PRX_RST_LED_DIV;
      smp_dly_reg   <= `PRX_RST_SMP_DLY;
      led_cur_reg   <= `PRX_RST_LED_CUR;
      uth_hi_reg    <= `PRX_RST_ZERO;
      uth_lo_reg    <= `PRX_RST_ZERO;
      lth_hi_reg    <= `PRX_RST_ZERO;
      lth_lo_reg    <= `PRX_RST_ZERO;
      filt_cfg_reg  <= `PRX_RST_ZERO;
      integ_cfg_reg <= `PRX_RST_ZERO;
      interval_reg  <= `PRX_RST_ZERO;
      mode_ctrl_reg <= `PRX_RST_ZERO;
    end
    else if (wr_strobe)
    begin
      if (ptr_reg == `PRX_ADDR_IRQ_CFG)
        irq_cfg_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_LED_DIV)
        led_div_reg <= shift_reg[`PRX_FIELD_MSB:0];
      else if (ptr_reg == `PRX_ADDR_SMP_DLY)
        smp_dly_reg <= shift_reg[`PRX_FIELD_MSB:0];
      else if (ptr_reg == `PRX_ADDR_LED_CUR)
        led_cur_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_UTH_HI)
        uth_hi_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_UTH_LO)
        uth_lo_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_LTH_HI)
        lth_hi_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_LTH_LO)
        lth_lo_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_FILT_CFG)
        filt_cfg_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_INTEG_CFG)
        integ_cfg_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_INTERVAL)
        interval_reg <= shift_reg;
      else if (ptr_reg == `PRX_ADDR_MODE_CTRL)
        mode_ctrl_reg <= shift_reg;
    end
  end

  // Soft reset armed by write, fired by the next STOP only
  always @(posedge clk_in)
  begin
    if (regs_rst)
    begin
      rst_armed_reg <= 1'b0;
      soft_rst_reg  <= 1'b0;
    end
    else
    begin
      soft_rst_reg <= stop_det & rst_armed_reg;
      if (wr_strobe && ptr_reg == `PRX_ADDR_SOFT_RST)
        rst_armed_reg <= shift_reg[`PRX_SOFT_RST_BIT];
    end
  end

  // Bus engine; bytes counted MSB first, ninth clock is the ack
  always @(posedge clk_in)
  begin
    if (regs_rst)
    begin
      state_reg        <= ST_IDLE;
      bit_cnt_reg      <= 4'h0;
      shift_reg        <= 8'h00;
      ptr_reg          <= 8'h00;
      ack_phase_reg    <= 1'b0;
      sda_drv_reg      <= 1'b0;
      sda_oe_out       <= 1'b0;
      hs_mode_out      <= 1'b0;
      res_lo_latch_reg <= 8'h00;
    end
    else if (stop_det)
    begin
      state_reg   <= ST_IDLE;
      sda_oe_out  <= 1'b0;
      hs_mode_out <= 1'b0;
    end
    else if (start_det)
    begin
      // Repeated START keeps high-speed mode and the pointer
      state_reg     <= ST_ADDR;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      sda_oe_out    <= 1'b0;
    end
    else if (state_reg != ST_IDLE && state_reg != ST_IGN)
    begin
      if (scl_rise && !ack_phase_reg && state_reg != ST_RDAT)
      begin
        shift_reg   <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (scl_rise && ack_phase_reg && state_reg == ST_RDAT && sda_s)
        state_reg <= ST_IGN;
      if (scl_fall)
      begin
        if (!ack_phase_reg && bit_cnt_reg == 4'h8)
        begin
          ack_phase_reg <= 1'b1;
          bit_cnt_reg   <= 4'h0;
          sda_oe_out    <= 1'b0;
          if (state_reg == ST_ADDR)
          begin
            if (shift_reg[7:1] == `PRX_SLAVE_ADDR)
            begin
              sda_oe_out <= 1'b1;
              state_reg  <= shift_reg[0] ? ST_RDAT : ST_PTR;
            end
            else
            begin
              if ((shift_reg & `PRX_HS_CODE_MASK) == `PRX_HS_CODE)
                hs_mode_out <= 1'b1;
              state_reg <= ST_IGN;
            end
          end
          else if (state_reg == ST_PTR)
          begin
            ptr_reg    <= shift_reg;
            sda_oe_out <= 1'b1;
            state_reg  <= ST_WDAT;
          end
          else if (state_reg == ST_WDAT)
          begin
            // Advance with the store so the pointer byte never moves it
            sda_oe_out <= 1'b1;
            ptr_reg    <= ptr_reg + 8'h01;
          end
          else
          begin
            // Read byte done; release for master ack
            ptr_reg <= ptr_reg + 8'h01;
          end
        end
        else if (ack_phase_reg)
        begin
          ack_phase_reg <= 1'b0;
          sda_oe_out    <= 1'b0;
          if (state_reg == ST_RDAT)
          begin
            // Load byte; low result byte frozen when high is read
            shift_reg   <= rd_data;
            sda_drv_reg <= rd_data[7];
            sda_oe_out  <= ~rd_data[7];
            bit_cnt_reg <= 4'h1;
            if (ptr_reg == `PRX_ADDR_RES_HI)
              res_lo_latch_reg <= measurement_result_in[7:0];
          end
        end
        else if (state_reg == ST_RDAT)
        begin
          shift_reg   <= {shift_reg[6:0], 1'b0};
          sda_oe_out  <= ~shift_reg[6];
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
    end
  end

  // LED divider; the reference tick is the 4 MHz time base
  reg [2:0] ref_cnt_reg;
  reg [4:0] div_cnt_reg;
  reg [6:0] dly_cnt_reg;
  reg       dly_run_reg;
  localparam integer REF_LAST_I = `PRX_REF_CYC - 1;
  wire [2:0] ref_last = REF_LAST_I[2:0];
  wire ref_tick = (ref_cnt_reg == ref_last);
  wire [4:0] half_div = {1'b0, led_div_reg[4:1]};

  always @(posedge clk_in)
  begin
    if (regs_rst)
    begin
      ref_cnt_reg   <= 3'h0;
      div_cnt_reg   <= 5'h00;
      led_pulse_out <= 1'b0;
    end
    else
    begin
      ref_cnt_reg <= ref_tick ? 3'h0 : ref_cnt_reg + 3'h1;
      if (ref_tick)
      begin
        // Divisors below 2 hold the LED output high with no pulses, invalid anyway
        if (div_cnt_reg >= led_div_reg - 5'h1 || led_div_reg < 5'h2)
        begin
          div_cnt_reg   <= 5'h00;
          led_pulse_out <= 1'b1;
        end
        else
        begin
          div_cnt_reg <= div_cnt_reg + 5'h1;
          if (div_cnt_reg + 5'h1 >= half_div)
            led_pulse_out <= 1'b0;
        end
      end
    end
  end

  // Sample strobe after (N-1) steps of 125 ns from each LED edge
  // 125 ns is not a whole number of clocks; each delay rounds up
  localparam integer STEP_NS_I = `PRX_STEP_NS;
  localparam integer CLK_NS_I  = `PRX_CLK_NS;
  reg         led_d_reg;
  wire        led_edge   = led_pulse_out ^ led_d_reg;
  wire [4:0]  dly_steps  = smp_dly_reg - 5'h01;
  wire [11:0] step_ns    = STEP_NS_I[11:0];
  wire [11:0] clk_ns     = CLK_NS_I[11:0];
  wire [11:0] dly_ns     = {7'h00, dly_steps} * step_ns;
  wire [11:0] dly_cyc    = (dly_ns + clk_ns - 12'h001) / clk_ns;
  wire [6:0]  dly_target = (smp_dly_reg < 5'h02) ? 7'h00 : dly_cyc[6:0];

  always @(posedge clk_in)
  begin
    if (regs_rst)
    begin
      led_d_reg     <= 1'b0;
      dly_cnt_reg   <= 7'h00;
      dly_run_reg   <= 1'b0;
      rx_sample_out <= 1'b0;
    end
    else
    begin
      led_d_reg     <= led_pulse_out;
      // Strobe is a single clock wide
      rx_sample_out <= 1'b0;
      if (led_edge)
      begin
        if (dly_target == 7'h00)
          rx_sample_out <= 1'b1;
        else
        begin
          // Starts at 2: edge detection already cost one clock
          dly_cnt_reg <= 7'h02;
          dly_run_reg <= 1'b1;
        end
      end
      else if (dly_run_reg)
      begin
        if (dly_cnt_reg >= dly_target)
        begin
          rx_sample_out <= 1'b1;
          dly_run_reg   <= 1'b0;
        end
        else
          dly_cnt_reg <= dly_cnt_reg + 7'h01;
      end
    end
  end
endmodule

// File: tb/prxi2c_host.sv
// Bus master model driving the block's I2C pins, 400 ns bit time
`timescale 1ns/1ps
module prxi2c_host (
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Clock held high between frames; repeated start when clock is low
  task start;
  begin
    if (!scl_out)
    begin
      #100 sda_low_out = 1'b0;
      #200 scl_out = 1'b1;
    end
    #200 sda_low_out = 1'b1;
    #200 scl_out = 1'b0;
  end
  endtask
  // Low phase 300 ns leaves room for the synchroniser delay
  task bit_x(input b, output r);
  begin
    #100 sda_low_out = !b;
    #200 scl_out = 1'b1;
    r = sda_in;
    #100 scl_out = 1'b0;
  end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_x(d[i], r);
    bit_x(1'b1, ack);
  end
  endtask
  task rbyte(input last, output [7:0] d);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  end
  endtask
  task stop;
  begin
    #100 sda_low_out = 1'b1;
    #200 scl_out = 1'b1;
    #200 sda_low_out = 1'b0;
    #200;
  end
  endtask
endmodule

// File: tb/prxi2c_monitor.sv
// Port checker for the proximity I2C register block
`timescale 1ns/1ps
module prxi2c_monitor (
  input wire       clk_in,
  input wire       srst_in,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_oe_out,
  input wire       hs_mode_out,
  input wire       led_pulse_out,
  input wire       rx_sample_out,
  input wire [7:0] led_drive_current_out,
  input wire [7:0] operation_mode_out
);
  reg       sda_q_reg;
  reg       scl_q_reg;
  reg [3:0] stop_age_reg;
  wire      stop_w;
  // Raw pins: the device answers a few cycles behind them
  assign stop_w = scl_in && scl_q_reg && sda_in && !sda_q_reg;
  always @(posedge clk_in)
  begin
    sda_q_reg <= sda_in;
    scl_q_reg <= scl_in;
    if (srst_in)
      stop_age_reg <= 4'hF;
    else if (stop_w)
      stop_age_reg <= 4'h0;
    else if (stop_age_reg != 4'hF)
      stop_age_reg <= stop_age_reg + 4'h1;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  a_reset_outs: assert property (srst_in |=> !sda_oe_out && !hs_mode_out && !led_pulse_out && !rx_sample_out)
    else $error("outputs not cleared by reset");
  a_reset_regs: assert property (srst_in |=> led_drive_current_out == 8'h09 && operation_mode_out == 8'h00)
    else $error("register outputs not at defaults after reset");
  a_sda_steady: assert property (disable iff (srst_in) scl_in && scl_q_reg |-> $stable(sda_oe_out))
    else $error("data line changed while clock high");
  a_hs_stop: assert property (disable iff (srst_in) stop_w |-> ##[1:5] !hs_mode_out)
    else $error("high-speed mode kept after stop");
  a_hs_hold: assert property (disable iff (srst_in) $fell(hs_mode_out) |-> stop_age_reg < 4'h6)
    else $error("high-speed mode left without stop");
  a_led_high: assert property (disable iff (srst_in) $rose(led_pulse_out) |=> led_pulse_out [*4])
    else $error("led high phase shorter than one reference tick");
  a_led_low: assert property (disable iff (srst_in) $fell(led_pulse_out) |=> !led_pulse_out [*4])
    else $error("led low phase shorter than one reference tick");
  a_sample_pulse: assert property (disable iff (srst_in) rx_sample_out |=> !rx_sample_out)
    else $error("sample strobe longer than one cycle");
  c_hs: cover property ($rose(hs_mode_out));
  c_ack: cover property ($rose(sda_oe_out));
  c_sample: cover property (rx_sample_out);
endmodule
bind prxi2c_top prxi2c_monitor u_mon (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_out(sda_oe_out), .hs_mode_out(hs_mode_out), .led_pulse_out(led_pulse_out),
  .rx_sample_out(rx_sample_out), .led_drive_current_out(led_drive_current_out),
  .operation_mode_out(operation_mode_out));

// File: tb/prxi2c_top_tb.sv
// Self-checking bench for the proximity I2C register block
`timescale 1ns/1ps
module prxi2c_top_tb;
  reg         clk_in;
  reg         srst_in;
  reg  [11:0] meas;
  wire        scl;
  wire        sda;
  wire        host_low;
  wire        sda_o;
  wire        sda_oe;
  wire        hs;
  wire        led;
  wire        smp;
  wire [7:0]  cur;
  wire [7:0]  mode;
  integer     n_fail;
  integer     n_checks;
  integer     i;
  integer     k;
  integer     c;
  integer     dt;
  time        t0;
  reg         ack;
  reg  [7:0]  rd [0:3];
  reg  [7:0]  wd [0:3];
  // Pull-up on the data line
  assign sda = !((sda_oe && !sda_o) || host_low);
  // Identity nibbles are arbitrary
  prxi2c_top #(.REV_ID(4'h0), .PART_NUM(4'hA)) uut (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .hs_mode_out(hs), .led_pulse_out(led),
    .rx_sample_out(smp), .measurement_result_in(meas), .led_drive_current_out(cur), .operation_mode_out(mode));
  prxi2c_host u_host (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task chk(input [8*12:1] nm, input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task wr(input [7:0] p, input integer n, input rs);
  begin
    u_host.start;
    u_host.wbyte(8'h6E, ack);
    chk("addr ack", ack, 16'h0);
    u_host.wbyte(p, ack);
    chk("ptr ack", ack, 16'h0);
    for (i = 0; i < n; i = i + 1)
    begin
      u_host.wbyte(wd[i], ack);
      chk("data ack", ack, 16'h0);
    end
    if (!rs)
      u_host.stop;
  end
  endtask
  task rdn(input [7:0] p, input integer n);
  begin
    wr(p, 0, 1);
    u_host.start;
    u_host.wbyte(8'h6F, ack);
    chk("read ack", ack, 16'h0);
    for (i = 0; i < n; i = i + 1)
      u_host.rbyte(i == n - 1, rd[i]);
    u_host.stop;
  end
  endtask
  task led_chk(input integer per, input integer dly);
  begin
    @(posedge led);
    @(posedge led);
    t0 = $time;
    @(posedge smp);
    dt = ($time - t0) / 50;
    chk("smp delay", dt[15:0], dly[15:0]);
    @(posedge led);
    dt = ($time - t0) / 50;
    chk("led period", dt[15:0], per[15:0]);
    // Bus edges kept off the sampling clock edge
    @(negedge clk_in);
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Whole run needs well under 1 ms of bus traffic
  initial
  begin
    #2000000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    srst_in = 1'b1;
    meas = 12'hABC;
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("cur out", cur, 16'h09);
    rdn(8'h0D, 3);
    chk("divisor", rd[0], 16'h10);
    chk("delay", rd[1], 16'h05);
    chk("current", rd[2], 16'h09);
    led_chk(80, 10);
    rdn(8'h00, 3);
    chk("part_identification", rd[0], 16'hA0);
    chk("rst reg", rd[1], 16'h00);
    chk("irq cfg", rd[2], 16'h02);
    rdn(8'h3F, 4);
    chk("unmapped", rd[0], 16'h00);
    chk("irq stat", rd[1], 16'h00);
    chk("result hi", rd[2], 16'h0A);
    chk("result lo", rd[3], 16'hBC);
    u_host.start;
    u_host.wbyte(8'h6C, ack);
    chk("wrong addr", ack, 16'h1);
    u_host.stop;
    for (k = 0; k < 4; k = k + 1)
      wd[k] = 8'h12 + 8'h22 * k[7:0];
    wr(8'h10, 4, 0);
    rdn(8'h10, 4);
    for (k = 0; k < 4; k = k + 1)
      chk("threshold", rd[k], wd[k]);
    wr(8'h41, 2, 0);
    rdn(8'h41, 2);
    chk("ro hi", rd[0], 16'h0A);
    chk("ro lo", rd[1], 16'hBC);
    wd[0] = 8'h5A;
    wr(8'h17, 1, 1);
    rdn(8'h17, 1);
    chk("mode", rd[0], 16'h5A);
    chk("mode out", mode, 16'h5A);
    // Upper bits set to show they are ignored; codes kept at or below the divisor
    wd[0] = 8'hE8;
    for (k = 0; k < 4; k = k + 1)
    begin
      c = (k == 3) ? 8 : k;
      wd[1] = 8'hE0 | c[7:0];
      wr(8'h0D, 2, 0);
      // Delay of (N-1) 125 ns steps, rounded up to whole 50 ns clocks
      led_chk(40, (c < 2) ? 1 : ((c - 1) * 125 + 49) / 50);
    end
    u_host.start;
    u_host.wbyte(8'h08, ack);
    chk("hs nack", ack, 16'h1);
    repeat (8) @(negedge clk_in);
    chk("hs on", hs, 16'h1);
    wd[0] = 8'h33;
    wr(8'h0F, 1, 1);
    chk("hs kept", hs, 16'h1);
    u_host.stop;
    chk("hs off", hs, 16'h0);
    chk("cur out", cur, 16'h33);
    wd[0] = 8'h01;
    wr(8'h01, 1, 1);
    // Stop placed in a low LED phase so the reset cuts no pulse short
    @(negedge led);
    @(negedge clk_in);
    u_host.stop;
    repeat (8) @(negedge clk_in);
    chk("cur rst", cur, 16'h09);
    chk("mode rst", mode, 16'h00);
    rdn(8'h0D, 4);
    chk("div rst", rd[0], 16'h10);
    chk("dly rst", rd[1], 16'h05);
    chk("th rst", rd[3], 16'h00);
    test_done;
  end
endmodule
